// ==== hdl/bte_branch_exec.sv ====
`default_nettype none
module bte_branch_exec #(
  // Machine word width; the carrier structs fix it at sixteen for now
  parameter int WORD_W = bte_pkg::WORD_W,
  // Width of the signed word offset in the low byte
  parameter int OFS_W = bte_pkg::OFS_W
) (
  // Core clock, rising edge
  input wire logic clk_i,
  // Synchronous reset, active low
  input wire logic rst_n_i,
  // Instruction word, qualifiers and updated pc from decode
  input wire bte_pkg::bte_req_t req_i,
  // Flags as they stand before the instruction
  input wire bte_pkg::bte_condition_flags_t condition_flags_i,
  // Next pc: target when taken, else the advanced pc
  output logic [15:0] pc_o,
  // High for one cycle after each valid request
  output logic pc_load_o,
  // High for one cycle after a taken branch
  output logic taken_o,
  // High for one cycle after a branch of either kind
  output logic is_branch_o,
  // Registered copy of the flags, never altered here
  output bte_pkg::bte_condition_flags_t condition_flags_o
);
  // One request per cycle; its answer stands for the next cycle only.
  // Nothing is buffered, so the pc register must take the answer then
  // or lose it: a stall has to hold the request on the input instead.

  // Offset field as it stands in the instruction
  wire logic [OFS_W-1:0] ofs_field;
  // Sign of the offset; set means a backward branch
  wire logic ofs_sign;
  // Offset widened to a full word, still counted in words
  wire logic [WORD_W-1:0] ofs_sext;
  // Offset as a byte displacement
  wire logic [WORD_W-1:0] ofs_bytes;
  // Branch destination; wraps around the top of memory
  wire logic [WORD_W-1:0] target;
  // High byte matches the unconditional opcode
  wire logic always_jump_op;
  // Request is a branch of either kind
  wire logic is_branch;
  // Request is a branch that will be taken
  wire logic take;
  // Next pc, target or fall-through
  wire logic [15:0] nxt_pc;

  // Registered results; every output comes straight from one of these
  logic [15:0] pc_ff; // Next pc for the pc register
  logic pc_load_ff; // A request was seen
  logic taken_ff; // That request was a taken branch
  logic is_branch_ff; // That request was a branch
  bte_pkg::bte_condition_flags_t flags_ff; // Flags copied through

  // Low byte holds the word offset
  assign ofs_field = req_i.instr[OFS_W-1:0];
  // Top bit of the field is the sign
  assign ofs_sign = ofs_field[bte_pkg::OFS_SIGN_POS];
  // Replicate sign so backward branches reach -128 words
  assign ofs_sext = {{(WORD_W-OFS_W){ofs_sign}}, ofs_field};
  // Doubling turns words into bytes and keeps the displacement even
  assign ofs_bytes = ofs_sext << bte_pkg::OFS_SCALE_SH;
  // Base is already past the branch word; the carry out is dropped
  assign target = req_i.upd_pc + ofs_bytes;
  // Opcode match on the high byte only; the low byte is the offset
  assign always_jump_op =
    (req_i.instr & bte_pkg::ALWAYS_JUMP_MASK) == bte_pkg::ALWAYS_JUMP_OP;
  // Either kind of branch, for the branch indication
  assign is_branch = req_i.valid && (always_jump_op || req_i.is_cond_branch);
  // Flag test lives in decode, so new conditions need no change here
  assign take = req_i.valid &&
    (always_jump_op || (req_i.is_cond_branch && req_i.cond_met));
  // Not taken falls through to the advanced pc
  assign nxt_pc = take ? target : req_i.upd_pc;

  // Result registers; one result per cycle, no stall
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // Cleared: nothing loads and nothing is taken
      pc_ff <= bte_pkg::PC_RST;
      pc_load_ff <= 1'h0;
      taken_ff <= 1'h0;
      is_branch_ff <= 1'h0;
      flags_ff <= bte_pkg::FLAGS_RST;
    end else begin
      // Answer to whatever stood on the input at this edge
      pc_ff <= nxt_pc;
      pc_load_ff <= req_i.valid;
      taken_ff <= take;
      is_branch_ff <= is_branch;
      // Flags pass untouched for every branch
      flags_ff <= condition_flags_i;
    end
  end

  // Outputs straight from the result registers
  assign pc_o = pc_ff;
  assign pc_load_o = pc_load_ff;
  assign taken_o = taken_ff;
  assign is_branch_o = is_branch_ff;
  assign condition_flags_o = flags_ff;

  // Each property samples on the core clock and checks the registered
  // answer one edge after the request; most idle while reset is held,
  // since the result registers are then forced to their cleared values.

  // Taken target is base plus the sign-extended offset times two,
  // written out from the instruction bits rather than the wires above
  a_taken_target: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    take |=> pc_o == $past(req_i.upd_pc) +
      {{7{$past(req_i.instr[7])}}, $past(req_i.instr[7:0]), 1'h0}
  ) else $error("taken branch target wrong");

  // Unconditional opcode is taken whatever decode says
  a_always_taken: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.instr[15:8] == 8'h01) |=> taken_o
  ) else $error("unconditional branch not taken");

  // Conditional branch with its test met is taken
  a_cond_taken: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && req_i.is_cond_branch && req_i.cond_met) |=> taken_o
  ) else $error("met condition not taken");

  // Decode's condition-met input alone gates a conditional branch;
  // a failed test must never be taken
  a_cond_gate: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && !always_jump_op && !req_i.cond_met) |=> !taken_o
  ) else $error("failed condition taken");

  // Not taken means the plain advanced pc
  a_fall_through: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && !take) |=> pc_o == $past(req_i.upd_pc)
  ) else $error("not taken pc wrong");

  // Zero offset lands on the word after the branch
  a_base_pc: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && ofs_field == 8'h00) |=> pc_o == $past(req_i.upd_pc)
  ) else $error("zero offset base wrong");

  // Sign bit set gives the full backward reach,
  // 128 words or 256 bytes below the base
  a_back_dir: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && ofs_field == 8'h80) |=> pc_o == $past(req_i.upd_pc) - 16'h0100
  ) else $error("backward reach wrong");

  // Largest forward offset, 127 words or 254 bytes
  // above the base, still fits the eight-bit field
  a_fwd_reach: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (take && ofs_field == 8'h7f) |=> pc_o == $past(req_i.upd_pc) + 16'h00fe
  ) else $error("forward reach wrong");

  // Doubling keeps the target on the same byte lane as the base;
  // a target whose low bit differs from the base's would mean the offset went in unscaled
  a_double_ofs: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    take |=> pc_o[0] == $past(req_i.upd_pc[0])
  ) else $error("offset not doubled");

  // A branch hands the flags on exactly as it found them
  a_flags_kept: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    is_branch |=> condition_flags_o == $past(condition_flags_i)
  ) else $error("branch changed flags");

  // Only the unconditional high byte is taken without decode's word
  a_opcode_dec: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (req_i.valid && !req_i.is_cond_branch && req_i.instr[15:8] != 8'h01)
      |=> !taken_o
  ) else $error("non branch taken");

  // Every valid request asks the pc register to load
  a_load_follows: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid |=> pc_load_o
  ) else $error("valid request did not load");

  // No request, no load and no branch indication
  a_idle_quiet: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !req_i.valid |=>
      !pc_load_o && !taken_o && !is_branch_o
  ) else $error("idle cycle produced a result");

  // Branch indication follows the decoded branch request
  a_branch_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    is_branch |=> is_branch_o
  ) else $error("branch not indicated");

  // Reset clears every result; checked with reset live, so the
  // usual disable is left off here on purpose
  a_reset_clear: assert property (
    @(posedge clk_i)
    !rst_n_i |=> !pc_load_o && !taken_o && !is_branch_o &&
      pc_o == bte_pkg::PC_RST && condition_flags_o == bte_pkg::FLAGS_RST
  ) else $error("reset left a result set");

  // Main scenarios worth seeing at least once
  c_uncond: cover property (@(posedge clk_i) req_i.valid && always_jump_op);
  c_cond_taken: cover property (@(posedge clk_i) take && !always_jump_op);
  c_cond_not: cover property (@(posedge clk_i) req_i.valid && req_i.is_cond_branch && !take);
  c_backward: cover property (@(posedge clk_i) take && ofs_sign);
  c_back_to_back: cover property (@(posedge clk_i) take ##1 take);
endmodule
`default_nettype wire

// ==== hdl/bte_pkg.sv ====
`default_nettype none
package bte_pkg;
  // Machine word and offset field widths
  localparam int WORD_W = 16;
  localparam int OFS_W = 8;
  // Offset sign bit position
  localparam int OFS_SIGN_POS = 7;
  // Word count to byte displacement: shift by one (times two)
  localparam int OFS_SCALE_SH = 1;
  // Unconditional branch opcode, high byte pattern (000400 octal)
  localparam logic [15:0] ALWAYS_JUMP_OP = 16'h0100;
  localparam logic [15:0] ALWAYS_JUMP_MASK = 16'hff00;
  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Negative, zero, overflow, carry
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bte_condition_flags_t;

  // One instruction presented by decode
  typedef struct packed {
    logic valid;
    logic is_cond_branch;
    logic cond_met;
    logic [15:0] instr;
    logic [15:0] upd_pc;
  } bte_req_t;
endpackage
`default_nettype wire

// ==== testbench/bte_fetch_model.sv ====
`default_nettype none
// Fetch side: presents one word with its updated pc
module bte_fetch_model (
  input wire logic valid_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] instr_i,
  input wire logic cond_i,
  input wire logic met_i,
  output bte_pkg::bte_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Base already past the branch word
  assign req_o = {valid_i, cond_i, met_i, instr_i, addr_i + 16'h0002};
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_n_i = 0, vld = 0, cnd = 0, met = 0, ld, tk, jmp;
  logic [15:0] adr = 0, ins = 0, pc, r;
  logic [15:0] exp_q [$];
  logic [7:0] bnd [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hfe, 8'hff};
  bte_pkg::bte_condition_flags_t fl = 4'h0, flo;
  bte_pkg::bte_req_t rq;
  int num_errors = 0, n_checks = 0, seed = 5, cyc = 0;
  always #5 clk_i = ~clk_i;
  bte_fetch_model fm_u (.valid_i(vld), .addr_i(adr), .instr_i(ins), .cond_i(cnd),
    .met_i(met), .req_o(rq));
  bte_branch_exec dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(rq),
    .condition_flags_i(fl), .pc_o(pc), .pc_load_o(ld), .taken_o(tk),
    .is_branch_o(jmp), .condition_flags_o(flo));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One request, answer checked one cycle later against integer model
  task automatic op(input logic v, input logic [15:0] i, input logic c, input logic m);
    int o;
    logic t;
    logic [15:0] e;
    vld = v;
    ins = i;
    cnd = c;
    met = m;
    adr = 16'($random(seed));
    fl = 4'($random(seed));
    o = i[7:0];
    if (o > 127) o -= 256;
    t = (i[15:8] == 8'h01) || (c && m);
    exp_q.push_back(t ? adr + 16'h0002 + 16'(2 * o) : adr + 16'h0002);
    @(posedge clk_i);
    #1;
    e = exp_q.pop_front();
    chk(16'(ld), 16'(v));
    chk(16'(tk), 16'(v && t));
    chk(16'(jmp), 16'(v && (i[15:8] == 8'h01 || c)));
    if (v) chk(pc, e);
    chk(16'(flo), 16'(fl));
  endtask
  // Hang guard
  always @(posedge clk_i) if (++cyc > 500) begin
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1;
    chk(pc, bte_pkg::PC_RST);
    chk(16'(ld), 16'h0000);
    chk(16'(tk), 16'h0000);
    chk(16'(flo), 16'(bte_pkg::FLAGS_RST));
    foreach (bnd[k]) op(1, {8'h01, bnd[k]}, k[0], 0);
    $display("test offsets done");
    op(1, 16'h02f0, 1, 1);
    op(1, 16'h02f0, 1, 0);
    op(1, 16'h1234, 0, 1);
    op(0, 16'h0105, 0, 0);
    $display("test conditions done");
    repeat (60) begin
      r = 16'($random(seed));
      op(r[15], {7'h00, r[8:0]}, r[10], r[11]);
    end
    $display("test random done");
    end_sim();
  end
endmodule
`default_nettype wire
